// File: core/pipm_axil.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Single clock, synchronous active-high reset
// Notes:   Answers one cycle after both write channels are held
`timescale 1ns/1ns
`include "pipm_map.svh"
module pipm_axil
(
    // System
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Write channels
    input  wire logic [`PIPM_ADDR_W-1:0] awaddr,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    // Read channels
    input  wire logic [`PIPM_ADDR_W-1:0] araddr,
    input  wire logic                    arvalid,
    output logic                         arready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    // Register side
    output logic                         wr_en,
    output logic [`PIPM_ADDR_W-1:0]      wr_addr,
    output logic [31:0]                  wr_data,
    output logic [3:0]                   wr_strb,
    input  wire logic                    wr_ok,
    output logic                         rd_en,
    output logic [`PIPM_ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]             rd_data,
    input  wire logic                    rd_ok
);
    logic have_aw;
    logic have_w;

    // Capture each write channel independently, then issue once both held
    assign awready = !have_aw && !bvalid;
    assign wready  = !have_w && !bvalid;
    assign wr_en   = have_aw && have_w && !bvalid;
    assign arready = !rvalid;
    assign rd_en   = arvalid && !rvalid;
    assign rd_addr = araddr;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            have_aw <= 1'b0;
            wr_addr <= '0;
        end
        else if (awvalid && awready)
        begin
            have_aw <= 1'b1;
            wr_addr <= awaddr;
        end
        else if (wr_en)
            have_aw <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            have_w  <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end
        else if (wvalid && wready)
        begin
            have_w  <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end
        else if (wr_en)
            have_w <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp  <= `PIPM_RESP_OKAY;
        end
        else if (wr_en)
        begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? `PIPM_RESP_OKAY : `PIPM_RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= `PIPM_RESP_OKAY;
        end
        else if (rd_en)
        begin
            rvalid <= 1'b1;
            rdata  <= rd_data;
            rresp  <= rd_ok ? `PIPM_RESP_OKAY : `PIPM_RESP_SLVERR;
        end
        else if (rready)
            rvalid <= 1'b0;
    end
endmodule

// File: core/pipm_map.svh
// Purpose: Register offsets, field positions and reset values of the pending mux
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes:   Offsets are local choices
`ifndef PIPM_MAP_SVH
`define PIPM_MAP_SVH

`define PIPM_ADDR_W          6
`define PIPM_OFS_PERIPH_PEND 6'h00
`define PIPM_OFS_PERIPH_MASK 6'h04
`define PIPM_OFS_MAIN_PEND   6'h08
`define PIPM_OFS_LOWER_EN    6'h0C
`define PIPM_OFS_UPPER_EN    6'h10
`define PIPM_OFS_IRQ_STAT    6'h14
`define PIPM_OFS_IRQ_MASK    6'h18

// Peripheral pending / mask bit positions
`define PIPM_BIT_TMR1        0
`define PIPM_BIT_TMR2        2
`define PIPM_BIT_SER0        4
`define PIPM_BIT_WAVE        4
`define PIPM_BIT_CMP5        6
`define PIPM_BIT_SER1        6

// Main enable bit positions (lower / upper enable registers)
`define PIPM_MAIN_TIMER      0
`define PIPM_UPPER_SERIAL    4
`define PIPM_UPPER_PERIPH    5
// Main pending register layout (local): 0 timer wrap, 1 serial error, 2 peripheral
`define PIPM_MP_TIMER        0
`define PIPM_MP_SERIAL       1
`define PIPM_MP_PERIPH       2

`define PIPM_PEND_RESET      8'h00
`define PIPM_MASK_RESET      8'h00
`define PIPM_EN_RESET        8'h00
`define PIPM_MP_RESET        3'h0

`define PIPM_RESP_OKAY       2'h0
`define PIPM_RESP_SLVERR     2'h2

`endif

// File: core/pipm_pkg.sv
// Purpose: Shared types of the pending mux
// Assumes: Constants come from pipm_map.svh
// Notes:   Variant selects which peripheral flags exist
package pipm_pkg;
    typedef enum logic [1:0]
    {
        PIPM_VAR_WAVE   = 2'h0,
        PIPM_VAR_CMP    = 2'h1,
        PIPM_VAR_SERIAL = 2'h2
    } pipm_variant_t;

    typedef logic [7:0] pipm_byte_t;
endpackage

// File: core/pipm_top.sv
// Purpose: Peripheral pending flags grouped onto shared interrupt sources
// Assumes: Event inputs are one-cycle pulses synchronous to clk
// Notes:   Main pending bits clear on vector acknowledge pulses
//
// Functional notes
// - Compare5 and waveform share the peripheral source
// - Upper enable bit 5 gates peripheral source
// - Peripheral mask bit 6 gates compare5 flag
// - Serial errors share source, upper enable bit 4
// - Peripheral mask bit 6 gates serial1 error
// - Peripheral mask bit 4 gates serial0 error
// - Timer1 and timer2 wraps share one source
// - Lower enable bit 0 gates timer wrap
// - Peripheral mask bit 2 gates timer2 wrap
// - Event sets peripheral flag and main flag
// - Reading peripheral pending clears all its flags
// - Software-set flag raises interrupt like hardware
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "pipm_map.svh"
module pipm_top
#(
    parameter pipm_pkg::pipm_variant_t VARIANT = pipm_pkg::PIPM_VAR_CMP
)
(
    // System
    input  wire logic                    clk,
    input  wire logic                    rst,
    // AXI4-Lite write
    input  wire logic [`PIPM_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`PIPM_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Peripheral events
    input  wire logic                    timer1_wrap_flag,
    input  wire logic                    timer2_wrap_flag,
    input  wire logic                    compare5_flag,
    input  wire logic                    waveform_flag,
    input  wire logic                    serial0_error_flag,
    input  wire logic                    serial1_error_flag,
    // CPU vectoring
    input  wire logic                    ack_timer_wrap,
    input  wire logic                    ack_serial_error,
    input  wire logic                    ack_peripheral,
    output logic                         shared_timer_wrap_source,
    output logic                         shared_serial_error_source,
    output logic                         shared_peripheral_source,
    output logic                         irq
);
    import pipm_pkg::*;

    localparam bit HAS_WAVE = (VARIANT != PIPM_VAR_SERIAL);
    localparam bit HAS_CMP  = (VARIANT == PIPM_VAR_CMP);
    localparam bit HAS_SER  = (VARIANT == PIPM_VAR_SERIAL);

    logic                    wr_en;
    logic [`PIPM_ADDR_W-1:0] wr_addr;
    logic [31:0]             wr_data;
    logic [3:0]              wr_strb;
    logic                    wr_ok;
    logic                    rd_en;
    logic [`PIPM_ADDR_W-1:0] rd_addr;
    logic [31:0]             rd_data;
    logic                    rd_ok;

    pipm_byte_t peripheral_pending_flags;
    pipm_byte_t peripheral_enable_mask;
    pipm_byte_t lower_interrupt_enable;
    pipm_byte_t upper_interrupt_enable;
    logic [2:0] main_pending_flags;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;

    pipm_byte_t implemented;
    pipm_byte_t hw_set;
    pipm_byte_t sw_set;
    pipm_byte_t new_flags;
    logic [2:0] main_set;
    logic [2:0] main_ack;
    logic       pend_read;
    logic       stat_read;

    // Only the flags of this variant exist; others read as zero
    always_comb
    begin
        implemented                 = '0;
        implemented[`PIPM_BIT_TMR1] = 1'b1;
        implemented[`PIPM_BIT_TMR2] = 1'b1;
        implemented[`PIPM_BIT_WAVE] = HAS_WAVE || HAS_SER;
        implemented[`PIPM_BIT_CMP5] = HAS_CMP || HAS_SER;
    end

    function automatic logic wr_hit(input logic [`PIPM_ADDR_W-1:0] ofs);
        wr_hit = wr_en && (wr_addr == ofs) && wr_strb[0];
    endfunction

    always_comb
    begin
        hw_set                 = '0;
        hw_set[`PIPM_BIT_TMR1] = timer1_wrap_flag;
        hw_set[`PIPM_BIT_TMR2] = timer2_wrap_flag;
        if (HAS_SER)
        begin
            hw_set[`PIPM_BIT_SER0] = serial0_error_flag;
            hw_set[`PIPM_BIT_SER1] = serial1_error_flag;
        end
        else
        begin
            hw_set[`PIPM_BIT_WAVE] = HAS_WAVE && waveform_flag;
            hw_set[`PIPM_BIT_CMP5] = HAS_CMP && compare5_flag;
        end
    end

    // Software writes of ones post flags just as events do
    assign sw_set    = wr_hit(`PIPM_OFS_PERIPH_PEND) ? (wr_data[7:0] & implemented) : '0;
    assign new_flags = hw_set | sw_set;

    // Timer1 always feeds; timer2 needs its mask bit
    assign main_set[`PIPM_MP_TIMER] = new_flags[`PIPM_BIT_TMR1]
        || (new_flags[`PIPM_BIT_TMR2] && peripheral_enable_mask[`PIPM_BIT_TMR2]);
    assign main_set[`PIPM_MP_SERIAL] = HAS_SER
        && ((new_flags[`PIPM_BIT_SER0] && peripheral_enable_mask[`PIPM_BIT_SER0])
         || (new_flags[`PIPM_BIT_SER1] && peripheral_enable_mask[`PIPM_BIT_SER1]));
    assign main_set[`PIPM_MP_PERIPH] = !HAS_SER
        && ((new_flags[`PIPM_BIT_CMP5] && peripheral_enable_mask[`PIPM_BIT_CMP5])
         || (new_flags[`PIPM_BIT_WAVE] && peripheral_enable_mask[`PIPM_BIT_WAVE]));

    assign main_ack  = {ack_peripheral, ack_serial_error, ack_timer_wrap};
    assign pend_read = rd_en && (rd_addr == `PIPM_OFS_PERIPH_PEND);
    assign stat_read = rd_en && (rd_addr == `PIPM_OFS_IRQ_STAT);

    // Read clears all flags, but a same-cycle set survives
    always_ff @(posedge clk)
    begin
        if (rst)
            peripheral_pending_flags <= `PIPM_PEND_RESET;
        else if (pend_read)
            peripheral_pending_flags <= new_flags;
        else
            peripheral_pending_flags <= peripheral_pending_flags | new_flags;
    end

    // Vector acknowledge clears; a new set wins
    always_ff @(posedge clk)
    begin
        if (rst)
            main_pending_flags <= `PIPM_MP_RESET;
        else
            main_pending_flags <= (main_pending_flags & ~main_ack) | main_set;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            peripheral_enable_mask <= `PIPM_MASK_RESET;
            lower_interrupt_enable <= `PIPM_EN_RESET;
            upper_interrupt_enable <= `PIPM_EN_RESET;
            irq_mask               <= `PIPM_MP_RESET;
        end
        else
        begin
            if (wr_hit(`PIPM_OFS_PERIPH_MASK))
                peripheral_enable_mask <= wr_data[7:0] & implemented;
            if (wr_hit(`PIPM_OFS_LOWER_EN))
                lower_interrupt_enable <= wr_data[7:0];
            if (wr_hit(`PIPM_OFS_UPPER_EN))
                upper_interrupt_enable <= wr_data[7:0];
            if (wr_hit(`PIPM_OFS_IRQ_MASK))
                irq_mask <= wr_data[2:0];
        end
    end

    // Requests toward the CPU, gated by main enables
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shared_timer_wrap_source   <= 1'b0;
            shared_serial_error_source <= 1'b0;
            shared_peripheral_source   <= 1'b0;
        end
        else
        begin
            shared_timer_wrap_source   <= main_pending_flags[`PIPM_MP_TIMER]
                && lower_interrupt_enable[`PIPM_MAIN_TIMER];
            shared_serial_error_source <= main_pending_flags[`PIPM_MP_SERIAL]
                && upper_interrupt_enable[`PIPM_UPPER_SERIAL];
            shared_peripheral_source   <= main_pending_flags[`PIPM_MP_PERIPH]
                && upper_interrupt_enable[`PIPM_UPPER_PERIPH];
        end
    end

    // Sticky status of main pending sets, not gated by the enables, for the bus interrupt; read clears, set wins
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_status <= `PIPM_MP_RESET;
        else if (stat_read)
            irq_status <= main_set;
        else
            irq_status <= irq_status | main_set;
    end

    assign irq = |(irq_status & irq_mask);

    always_comb
    begin
        rd_data = '0;
        rd_ok   = 1'b1;
        case (rd_addr)
            `PIPM_OFS_PERIPH_PEND: rd_data[7:0] = peripheral_pending_flags;
            `PIPM_OFS_PERIPH_MASK: rd_data[7:0] = peripheral_enable_mask;
            `PIPM_OFS_MAIN_PEND:   rd_data[2:0] = main_pending_flags;
            `PIPM_OFS_LOWER_EN:    rd_data[7:0] = lower_interrupt_enable;
            `PIPM_OFS_UPPER_EN:    rd_data[7:0] = upper_interrupt_enable;
            `PIPM_OFS_IRQ_STAT:    rd_data[2:0] = irq_status;
            `PIPM_OFS_IRQ_MASK:    rd_data[2:0] = irq_mask;
            default:               rd_ok        = 1'b0;
        endcase
    end

    always_comb
    begin
        case (wr_addr)
            `PIPM_OFS_PERIPH_PEND,
            `PIPM_OFS_PERIPH_MASK,
            `PIPM_OFS_LOWER_EN,
            `PIPM_OFS_UPPER_EN,
            `PIPM_OFS_IRQ_MASK:    wr_ok = 1'b1;
            default:               wr_ok = 1'b0;
        endcase
    end

    pipm_axil u_axil
    (
        .clk     (clk),
        .rst     (rst),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );
endmodule

// File: test/pipm_periph_model.sv
// Purpose: Peripherals and vector logic beside the pending mux
// Assumes: Events and acks are one-cycle pulses
// Notes:   Index 0..5 events, 6..8 acks timer, serial, peripheral
`timescale 1ns/1ns
module pipm_periph_model
(
    // System
    input wire logic clk,
    // Events
    output logic     timer1_wrap_flag,
    output logic     timer2_wrap_flag,
    output logic     compare5_flag,
    output logic     waveform_flag,
    output logic     serial0_error_flag,
    output logic     serial1_error_flag,
    // Vector taken
    output logic     ack_timer_wrap,
    output logic     ack_serial_error,
    output logic     ack_peripheral
);
    logic [8:0] drv = 9'h000;

    assign {ack_peripheral, ack_serial_error, ack_timer_wrap, serial1_error_flag, serial0_error_flag,
            waveform_flag, compare5_flag, timer2_wrap_flag, timer1_wrap_flag} = drv;

    task pulse(input int i);
        @(posedge clk);
        drv[i] <= 1'b1;
        @(posedge clk);
        drv[i] <= 1'b0;
    endtask
endmodule

// File: test/pipm_top_sva.sv
// Purpose: Port-level checks of the pending mux
// Assumes: One clock, rst synchronous active high
// Notes:   Register contents are not visible here
`timescale 1ns/1ns
module pipm_chk
(
    // System
    input wire logic        clk,
    input wire logic        rst,
    // Bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Events and vectoring
    input wire logic        timer1_wrap_flag,
    input wire logic        timer2_wrap_flag,
    input wire logic        compare5_flag,
    input wire logic        waveform_flag,
    input wire logic        ack_timer_wrap,
    input wire logic        ack_peripheral,
    input wire logic        shared_timer_wrap_source,
    input wire logic        shared_peripheral_source
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    a_timer_ack: assert property (ack_timer_wrap && !timer1_wrap_flag && !timer2_wrap_flag
        |=> ##1 !shared_timer_wrap_source) else $error("timer source survives ack");
    a_periph_ack: assert property (ack_peripheral && !compare5_flag && !waveform_flag
        |=> ##1 !shared_peripheral_source) else $error("peripheral source survives ack");
    // Source may rise only after an event or a register write
    a_timer_cause: assert property ($rose(shared_timer_wrap_source)
        |-> $past(timer1_wrap_flag || timer2_wrap_flag, 2) || $past(s_axi_bvalid))
        else $error("timer source without cause");
endmodule

bind pipm_top pipm_chk u_pipm_chk
(
    .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .timer1_wrap_flag, .timer2_wrap_flag, .compare5_flag, .waveform_flag,
    .ack_timer_wrap, .ack_peripheral, .shared_timer_wrap_source, .shared_peripheral_source
);

// File: test/pipm_top_tb.sv
// Purpose: Self-checking bench of the pending mux
// Assumes: Compare variant, bus answers whenever it is ready
// Notes:   Offsets and layout come from the map header
`timescale 1ns/1ns
`include "pipm_map.svh"
module pipm_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  s_axi_awaddr = 6'h00;
    logic [5:0]  s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    logic        timer1_wrap_flag, timer2_wrap_flag, compare5_flag, waveform_flag;
    logic        serial0_error_flag, serial1_error_flag, ack_timer_wrap, ack_serial_error;
    logic        ack_peripheral, shared_timer_wrap_source, shared_serial_error_source;
    logic        shared_peripheral_source, irq;
    int          error_cnt = 0;
    int          cmp_count = 0;

    always #4 clk = ~clk;

    pipm_top u_pipm_top
    (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .timer1_wrap_flag, .timer2_wrap_flag, .compare5_flag, .waveform_flag, .serial0_error_flag,
        .serial1_error_flag, .ack_timer_wrap, .ack_serial_error, .ack_peripheral,
        .shared_timer_wrap_source, .shared_serial_error_source, .shared_peripheral_source, .irq
    );

    pipm_periph_model u_pipm_periph_model
    (
        .clk, .timer1_wrap_flag, .timer2_wrap_flag, .compare5_flag, .waveform_flag,
        .serial0_error_flag, .serial1_error_flag, .ack_timer_wrap, .ack_serial_error, .ack_peripheral
    );

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Each channel drops at the edge that takes it; late bready exercises response hold
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        repeat (2) @(posedge clk);
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        // Late rready so read data must hold
        @(posedge clk);
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic ev(input int i);
        u_pipm_periph_model.pulse(i);
        tick(2);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 7; i++)
        begin
            rd(6'(i * 4));
            chk(rdat, 32'h0);
            chk(resp, `PIPM_RESP_OKAY);
        end
    endtask

    task automatic t_bus_err;
        rd(6'h1C);
        chk(rdat, 32'h0);
        chk(resp, `PIPM_RESP_SLVERR);
        wr(`PIPM_OFS_MAIN_PEND, 32'h7);
        chk(resp, `PIPM_RESP_SLVERR);
        rd(`PIPM_OFS_MAIN_PEND);
        chk(rdat, 32'h0);
        // Low byte strobe off: accepted, nothing changes
        s_axi_wstrb <= 4'hE;
        wr(`PIPM_OFS_IRQ_MASK, 32'h7);
        chk(resp, `PIPM_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`PIPM_OFS_IRQ_MASK);
        chk(rdat, 32'h0);
    endtask

    task automatic t_timer;
        ev(1);
        rd(`PIPM_OFS_PERIPH_PEND);
        chk(rdat, 32'h04);
        rd(`PIPM_OFS_MAIN_PEND);
        chk(rdat, 32'h0);
        rd(`PIPM_OFS_PERIPH_PEND);
        chk(rdat, 32'h0);
        wr(`PIPM_OFS_PERIPH_MASK, 32'h04);
        wr(`PIPM_OFS_LOWER_EN, 32'h01);
        ev(1);
        chk(shared_timer_wrap_source, 1'b1);
        rd(`PIPM_OFS_MAIN_PEND);
        chk(rdat, 32'h1);
        ev(6);
        chk(shared_timer_wrap_source, 1'b0);
        wr(`PIPM_OFS_LOWER_EN, 32'h00);
        ev(0);
        chk(shared_timer_wrap_source, 1'b0);
        wr(`PIPM_OFS_LOWER_EN, 32'h01);
        tick(2);
        chk(shared_timer_wrap_source, 1'b1);
        ev(6);
        rd(`PIPM_OFS_PERIPH_PEND);
    endtask

    task automatic t_periph;
        wr(`PIPM_OFS_UPPER_EN, 32'h30);
        wr(`PIPM_OFS_PERIPH_MASK, 32'h50);
        // Serial errors do not exist in this variant
        ev(4);
        ev(5);
        chk(shared_serial_error_source, 1'b0);
        chk(shared_peripheral_source, 1'b0);
        wr(`PIPM_OFS_PERIPH_MASK, 32'h40);
        ev(3);
        chk(shared_peripheral_source, 1'b0);
        ev(2);
        chk(shared_peripheral_source, 1'b1);
        ev(8);
        chk(shared_peripheral_source, 1'b0);
        wr(`PIPM_OFS_PERIPH_MASK, 32'h10);
        ev(3);
        chk(shared_peripheral_source, 1'b1);
        ev(8);
        wr(`PIPM_OFS_PERIPH_MASK, 32'h40);
        wr(`PIPM_OFS_PERIPH_PEND, 32'h40);
        tick(2);
        chk(shared_peripheral_source, 1'b1);
        wr(`PIPM_OFS_UPPER_EN, 32'h00);
        tick(2);
        chk(shared_peripheral_source, 1'b0);
        rd(`PIPM_OFS_MAIN_PEND);
        chk(rdat, 32'h4);
        ev(8);
        rd(`PIPM_OFS_PERIPH_PEND);
    endtask

    task automatic t_irq;
        rd(`PIPM_OFS_IRQ_STAT);
        wr(`PIPM_OFS_IRQ_MASK, 32'h0);
        ev(2);
        chk(irq, 1'b0);
        rd(`PIPM_OFS_IRQ_STAT);
        chk(rdat, 32'h4);
        wr(`PIPM_OFS_IRQ_MASK, 32'h4);
        ev(2);
        chk(irq, 1'b1);
        rd(`PIPM_OFS_IRQ_STAT);
        chk(rdat, 32'h4);
        tick(1);
        chk(irq, 1'b0);
        ev(8);
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_bus_err();
        t_timer();
        t_periph();
        t_irq();
        wrap_up();
    end
endmodule
